// ---- smbus_flag_pkg.sv ----
/*
 * constants and carrier types for the two-wire flag and address-match block.
 * assumes a byte-wide special-function-register port from the cpu core.
 */
package smbus_flag_pkg;

   localparam logic [7:0] CTL_OFFSET      = 8'hc0;
   localparam logic [7:0] DATA_OFFSET     = 8'hc2;
   localparam logic [7:0] OWN_OFFSET      = 8'hf4;
   localparam logic [7:0] MASK_OFFSET     = 8'hf5;

   localparam logic [7:0] CTL_RESET       = 8'h00;
   localparam logic [7:0] DATA_RESET      = 8'h00;
   localparam logic [7:0] OWN_RESET       = 8'h00;
   localparam logic [7:0] MASK_RESET      = 8'hfe;

   localparam int         ADDR_MSB        = 7;
   localparam int         ADDR_LSB        = 1;
   localparam int         ENABLE_BIT      = 0;
   localparam logic [6:0] ALL_CALL_ADDR   = 7'h00;
   localparam logic [3:0] LAST_DATA_BIT   = 4'h7;
   localparam logic [3:0] ACK_SLOT        = 4'h8;
   localparam logic       PIN_LOW         = 1'b0;

   // bit layout of the control/flag register, msb first
   typedef struct packed {
      logic master;
      logic transmitter_flag;
      logic begin_seen_flag;
      logic halt_condition_flag;
      logic ack_response_needed;
      logic arbitration_lost_flag;
      logic ack;
      logic si;
   } ctl_flags_t;

   // events from the bit-level transfer engine
   typedef struct packed {
      logic start_gen;
      logic stop_gen;
      logic scl_low_cond;
      logic tx_one;
   } engine_evt_t;

   // register port request
   typedef struct packed {
      logic       wr;
      logic       rd;
      logic [7:0] addr;
      logic [7:0] wdata;
   } sfr_req_t;

endpackage

// ---- smbus_flag_match.sv ----
/*
 * status flags and slave address recognition for a two-wire bus port.
 * assumes scl/sda come from pads (open drain, pulled up) and the engine
 * events arrive as one-cycle pulses or levels on clk_i.
 */
// Overview of operation
// RL1: master flag set on start, cleared stop/arb
// RL2: transmit flag follows start, detect, data write
// RL3: start-seen set by address byte, software clears
// RL4: stop flag on slave stop or stop arbitration
// RL5: ack request per received byte, software mode
// RL6: arbitration lost four ways, cleared with interrupt
// RL7: ack bit tracks sampled acknowledge slot
// RL8: interrupt flag on listed events, software clears
// RL9: auto enable gives recognition and automatic ack
// RL10: masked seven-bit address compare
// RL11: general call recognised when all-call enabled
// RL12: own address bits seven-one, all-call bit zero
// RL13: address 0x70 mask 0x73 matches four addresses
// RL14: mask bits seven-one, auto enable bit zero
// RL15: unacked address ignores slave events until start
// RL16: interrupt flag holds scl low
// RL17: compare uses upper seven bits of address
module smbus_flag_match
   import smbus_flag_pkg::*;
#(
   parameter int unsigned ADDR_BITS = 7
) (
   input  wire logic                       clk_i,
   input  wire logic                       rstn_i,
   input  wire smbus_flag_pkg::sfr_req_t    sfr_i,
   output logic [7:0]                       sfr_rdata_o,
   input  wire smbus_flag_pkg::engine_evt_t evt_i,
   input  wire logic                       scl_i,
   output logic                            scl_o,
   output logic                            scl_oe_o,
   input  wire logic                       sda_i,
   output logic                            sda_o,
   output logic                            sda_oe_o,
   output smbus_flag_pkg::ctl_flags_t       flags_o,
   output logic                            addressed_o
);
   import smbus_flag_pkg::*;

   if (ADDR_BITS != 7) begin : g_check
      $error("only seven-bit addressing is supported");
   end

   function automatic logic addr_match(input logic [6:0] rx,
                                       input logic [7:0] own,
                                       input logic [7:0] msk);
      addr_match = (((rx ^ own[ADDR_MSB:ADDR_LSB]) & msk[ADDR_MSB:ADDR_LSB])
                    == 7'h00)                                            // RL10
                   || (own[ENABLE_BIT] && rx == ALL_CALL_ADDR);          // RL11
   endfunction

   // pin synchronisers and edge history
   logic [2:0] scl_sync_reg, scl_sync_next;
   logic [2:0] sda_sync_reg, sda_sync_next;
   // bus tracking
   logic [3:0] cnt_reg, cnt_next;
   logic [7:0] shift_reg, shift_next;
   logic       addr_phase_reg, addr_phase_next;
   logic       addressed_reg, addressed_next;
   logic       ack_drive_reg, ack_drive_next;
   logic       data_written_reg, data_written_next;
   // registers
   ctl_flags_t ctl_reg, ctl_next;
   logic [7:0] own_reg, own_next;
   logic [7:0] mask_reg, mask_next;
   logic [7:0] data_reg, data_next;
   logic [7:0] rdata_reg, rdata_next;

   logic scl_s, scl_q, sda_s, sda_q;
   logic scl_rise, scl_fall, start_det, stop_det;
   logic byte_done, ack_rise, auto_ack, match, busy;
   logic wr_ctl, frame_begin, arb_lost, drive_ack;
   logic ev_tx_acked, ev_rx_byte, ev_addr, ev_stop, sw_ack_request;

   always_comb begin
      scl_sync_next = {scl_sync_reg[1:0], scl_i};
      sda_sync_next = {sda_sync_reg[1:0], sda_i};
   end

   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         scl_sync_reg <= 3'h7;
         sda_sync_reg <= 3'h7;
      end else begin
         scl_sync_reg <= scl_sync_next;
         sda_sync_reg <= sda_sync_next;
      end
   end

   always_comb begin
      scl_s     = scl_sync_reg[1];
      scl_q     = scl_sync_reg[2];
      sda_s     = sda_sync_reg[1];
      sda_q     = sda_sync_reg[2];
      scl_rise  = scl_s && !scl_q;
      scl_fall  = !scl_s && scl_q;
      start_det = scl_s && scl_q && !sda_s && sda_q;
      stop_det  = scl_s && scl_q && sda_s && !sda_q;
      byte_done = scl_rise && cnt_reg == LAST_DATA_BIT;
      ack_rise  = scl_rise && cnt_reg == ACK_SLOT;
      auto_ack  = mask_reg[ENABLE_BIT];                                  // RL14
      match     = addr_match(shift_reg[7:1], own_reg, mask_reg);         // RL17
      busy      = ctl_reg.master || addressed_reg;
      wr_ctl    = sfr_i.wr && sfr_i.addr == CTL_OFFSET;
      frame_begin = wr_ctl && ctl_reg.si && !sfr_i.wdata[0];
      // arbitration loss sources
      arb_lost  = (start_det && ctl_reg.master
                   && !ctl_reg.begin_seen_flag)                          // RL6
               || evt_i.scl_low_cond                                     // RL6
               || (scl_rise && evt_i.tx_one && !sda_s
                   && cnt_reg != ACK_SLOT && ctl_reg.master)             // RL6
               || (stop_det && ctl_reg.master && !evt_i.stop_gen);       // RL4
      // interrupt sources
      ev_tx_acked = ack_rise && busy && ctl_reg.transmitter_flag;        // RL8
      ev_rx_byte  = !addr_phase_reg && busy && !ctl_reg.transmitter_flag
                 && (auto_ack ? ack_rise : byte_done);                   // RL8
      ev_addr     = addr_phase_reg && !ctl_reg.master
                 && (auto_ack ? (ack_rise && match) : byte_done);        // RL9
      ev_stop     = stop_det && addressed_reg;                           // RL8
      sw_ack_request = !auto_ack && byte_done && !ctl_reg.transmitter_flag
                 && (addr_phase_reg ? !ctl_reg.master : busy);           // RL5
      // ack value driven by this end in the slot
      if (addr_phase_reg)
         drive_ack = !ctl_reg.master && (auto_ack ? match : ctl_reg.ack);
      else
         drive_ack = busy && !ctl_reg.transmitter_flag && ctl_reg.ack;
   end

   // bus tracking state
   always_comb begin
      cnt_next        = cnt_reg;
      shift_next      = shift_reg;
      addr_phase_next = addr_phase_reg;
      addressed_next  = addressed_reg;
      ack_drive_next  = ack_drive_reg;
      if (start_det) begin
         cnt_next        = 4'h0;
         addr_phase_next = 1'b1;
         addressed_next  = 1'b0;                                         // RL15
         ack_drive_next  = 1'b0;
      end else if (stop_det) begin
         addr_phase_next = 1'b0;
         addressed_next  = 1'b0;
         ack_drive_next  = 1'b0;
      end else if (scl_fall) begin
         ack_drive_next = (cnt_reg == ACK_SLOT) && drive_ack;            // RL9
      end else if (cnt_reg == ACK_SLOT && !scl_s) begin
         ack_drive_next = drive_ack;
      end else if (ctl_reg.si) begin
         ack_drive_next = ack_drive_reg;                                 // RL16
      end else if (scl_rise) begin
         if (cnt_reg == ACK_SLOT) begin
            cnt_next = 4'h0;
            if (addr_phase_reg) begin
               addr_phase_next = 1'b0;
               addressed_next  = drive_ack;                              // RL15
            end
         end else begin
            cnt_next   = cnt_reg + 4'h1;
            shift_next = {shift_reg[6:0], sda_s};
         end
      end
   end

   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         cnt_reg        <= 4'h0;
         shift_reg      <= 8'h00;
         addr_phase_reg <= 1'b0;
         addressed_reg  <= 1'b0;
         ack_drive_reg  <= 1'b0;
      end else begin
         cnt_reg        <= cnt_next;
         shift_reg      <= shift_next;
         addr_phase_reg <= addr_phase_next;
         addressed_reg  <= addressed_next;
         ack_drive_reg  <= ack_drive_next;
      end
   end

   // registers and flags; hardware sets win over software clears
   always_comb begin
      ctl_next          = ctl_reg;
      own_next          = own_reg;
      mask_next         = mask_reg;
      data_next         = data_reg;
      data_written_next = data_written_reg;
      rdata_next        = rdata_reg;
      if (sfr_i.wr) begin
         case (sfr_i.addr)
            CTL_OFFSET: begin
               ctl_next.begin_seen_flag     = sfr_i.wdata[5];
               ctl_next.halt_condition_flag = sfr_i.wdata[4];
               ctl_next.ack = sfr_i.wdata[1];
               ctl_next.si  = sfr_i.wdata[0];
            end
            DATA_OFFSET: begin
               data_next         = sfr_i.wdata;
               data_written_next = 1'b1;
            end
            OWN_OFFSET:  own_next  = sfr_i.wdata;                        // RL12
            MASK_OFFSET: mask_next = sfr_i.wdata;                        // RL14
            default:     data_written_next = data_written_reg;
         endcase
      end
      if (frame_begin) begin
         ctl_next.transmitter_flag      = data_written_reg;              // RL2
         data_written_next              = 1'b0;
         ctl_next.arbitration_lost_flag = 1'b0;                          // RL6
      end
      if (start_det) ctl_next.transmitter_flag = 1'b0;                   // RL2
      if (arb_lost) begin
         ctl_next.master                = 1'b0;                          // RL1
         ctl_next.transmitter_flag      = 1'b0;                          // RL2
         ctl_next.arbitration_lost_flag = 1'b1;                          // RL6
      end
      if (evt_i.stop_gen) begin
         ctl_next.master              = 1'b0;                            // RL1
         ctl_next.halt_condition_flag = 1'b0;                            // RL4
      end
      if (evt_i.start_gen) begin
         ctl_next.master           = 1'b1;                               // RL1
         ctl_next.transmitter_flag = 1'b1;                               // RL2
      end
      if (addr_phase_reg && byte_done)
         ctl_next.begin_seen_flag = 1'b1;                                // RL3
      if (ev_stop || (stop_det && arb_lost))
         ctl_next.halt_condition_flag = 1'b1;                            // RL4
      if (ack_rise) ctl_next.ack_response_needed = 1'b0;                 // RL5
      if (sw_ack_request) ctl_next.ack_response_needed = 1'b1;           // RL5
      if (ack_rise && ctl_reg.transmitter_flag)
         ctl_next.ack = !sda_s;                                          // RL7
      if (byte_done) data_next = {shift_reg[6:0], sda_s};
      if (evt_i.start_gen || arb_lost || ev_tx_acked || ev_rx_byte
          || ev_addr || ev_stop)
         ctl_next.si = 1'b1;                                             // RL8
      if (sfr_i.rd) begin
         case (sfr_i.addr)
            CTL_OFFSET:  rdata_next = ctl_reg;
            DATA_OFFSET: rdata_next = data_reg;
            OWN_OFFSET:  rdata_next = own_reg;
            MASK_OFFSET: rdata_next = mask_reg;
            default:     rdata_next = 8'h00;
         endcase
      end
   end

   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         ctl_reg          <= CTL_RESET;
         own_reg          <= OWN_RESET;
         mask_reg         <= MASK_RESET;
         data_reg         <= DATA_RESET;
         data_written_reg <= 1'b0;
         rdata_reg        <= 8'h00;
      end else begin
         ctl_reg          <= ctl_next;
         own_reg          <= own_next;
         mask_reg         <= mask_next;
         data_reg         <= data_next;
         data_written_reg <= data_written_next;
         rdata_reg        <= rdata_next;
      end
   end

   always_comb begin
      sfr_rdata_o = rdata_reg;
      flags_o     = ctl_reg;
      addressed_o = addressed_reg;
      scl_o       = PIN_LOW;
      scl_oe_o    = ctl_reg.si;                                          // RL16
      sda_o       = PIN_LOW;
      sda_oe_o    = ack_drive_reg;
   end

   // checks
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!rstn_i);

   sequence s_addr_byte_in;
      addr_phase_reg && byte_done && !arb_lost;
   endsequence
   sequence s_flag_seen;
      ctl_reg.begin_seen_flag && ctl_reg.si;
   endsequence

   a_master_on_start: assert property (                                  // RL1
      evt_i.start_gen |=> ctl_reg.master && ctl_reg.transmitter_flag)
      else $error("start generation did not set master and transmit");
   a_master_drop: assert property (                                      // RL1
      arb_lost && !evt_i.start_gen
      |=> !ctl_reg.master && ctl_reg.arbitration_lost_flag)
      else $error("arbitration loss left master set");
   a_start_seen_hold: assert property (                                  // RL3
      ctl_reg.begin_seen_flag && !wr_ctl |=> ctl_reg.begin_seen_flag)
      else $error("start-seen flag cleared by hardware");
   a_start_seen_set: assert property (                                   // RL3
      s_addr_byte_in |=> s_flag_seen or ctl_reg.begin_seen_flag)
      else $error("address byte did not set start-seen");
   a_stop_pending: assert property (                                     // RL4
      evt_i.stop_gen && !arb_lost |=> !ctl_reg.halt_condition_flag)
      else $error("stop flag stayed after generated stop");
   a_ack_request_clear: assert property (                                // RL5
      ack_rise && !sw_ack_request |=> !ctl_reg.ack_response_needed)
      else $error("ack request not cleared by ack slot");
   a_ack_sample: assert property (                                       // RL7
      ack_rise && ctl_reg.transmitter_flag
      |=> ctl_reg.ack == !$past(sda_s))
      else $error("ack bit does not match sampled slot");
   a_si_sticky: assert property (                                        // RL8
      ctl_reg.si && !wr_ctl |=> ctl_reg.si)
      else $error("interrupt flag cleared without software");
   a_nack_silent: assert property (                                      // RL15
      !addressed_reg && !ctl_reg.master && !addr_phase_reg && !start_det
      |-> !ev_rx_byte && !ev_stop)
      else $error("slave event raised while not addressed");
   a_scl_held: assert property (                                         // RL16
      ctl_reg.si |-> scl_oe_o && !scl_o)
      else $error("scl released while interrupt pending");
   a_mask_example: assert property (                                     // RL13
      own_reg[7:1] == 7'h70 && mask_reg[7:1] == 7'h73 && !own_reg[0]
      |-> match == (shift_reg[7:5] == 3'h7
                    && shift_reg[2:1] == 2'h0))
      else $error("masked compare example mismatch");

endmodule // smbus_flag_match

// ---- bus_master_model.sv ----
/*
 * bus master model for the two-wire link: start, byte with ack slot, stop.
 * assumes the bench resolves both wires as open drain with pull-ups.
 */
module bus_master_model (
   output logic      scl_low_o,
   output logic      sda_low_o,
   input  wire logic scl_i,
   input  wire logic sda_i
);
   timeunit 1ns;
   timeprecision 1ns;
   localparam int QTR = 100;

   initial begin
      scl_low_o = 1'b0;
      sda_low_o = 1'b0;
   end

   // release scl, wait out stretching by the slave
   task automatic rise_scl();
      int n;
      n = 0;
      scl_low_o = 1'b0;
      while (scl_i !== 1'b1 && n < 4000) begin
         #QTR;
         n++;
      end
   endtask

   task automatic send_bit(input logic b);
      sda_low_o = ~b;
      #QTR;
      rise_scl();
      #(2*QTR);
      scl_low_o = 1'b1;
      #QTR;
   endtask

   // start, one byte msb first, ack slot sampled while scl high
   task automatic xfer(input logic [7:0] b, output logic ack_low);
      sda_low_o = 1'b1;
      #(2*QTR);
      scl_low_o = 1'b1;
      #QTR;
      for (int i = 7; i >= 0; i--) begin
         send_bit(b[i]);
      end
      sda_low_o = 1'b0;
      #QTR;
      rise_scl();
      #QTR;
      ack_low = (sda_i === 1'b0);
      #QTR;
      scl_low_o = 1'b1;
      #QTR;
   endtask

   task automatic stop();
      sda_low_o = 1'b1;
      #QTR;
      rise_scl();
      #(2*QTR);
      sda_low_o = 1'b0;
      #(2*QTR);
   endtask
endmodule // bus_master_model

// ---- smbus_flag_and_address_match_bench.sv ----
/*
 * self-checking bench for the flag and address-match block.
 * assumes the bus master model and open-drain wires with pull-ups.
 */
module smbus_flag_and_address_match_bench;
   timeunit 1ns;
   timeprecision 1ns;
   import smbus_flag_pkg::*;

   logic        clk_i = 1'b0;
   logic        rstn_i = 1'b0;
   sfr_req_t    sfr;
   engine_evt_t evt;
   ctl_flags_t  flags;
   logic [7:0]  rdata;
   logic        scl_o, scl_oe, sda_o, sda_oe, addressed;
   logic        m_scl_low, m_sda_low, tb_scl_low, tb_sda_low;
   logic        rd_q = 1'b0;
   logic [15:0] note_q[$];
   logic [31:0] tab[10];
   int          n_mismatch = 0;
   int          cmp_count = 0;
   wire         scl_w = ~((scl_oe & ~scl_o) | m_scl_low | tb_scl_low);
   wire         sda_w = ~((sda_oe & ~sda_o) | m_sda_low | tb_sda_low);

   always #25 clk_i = ~clk_i;

   smbus_flag_match dut (.clk_i(clk_i), .rstn_i(rstn_i), .sfr_i(sfr),
      .sfr_rdata_o(rdata), .evt_i(evt), .scl_i(scl_w), .scl_o(scl_o),
      .scl_oe_o(scl_oe), .sda_i(sda_w), .sda_o(sda_o), .sda_oe_o(sda_oe),
      .flags_o(flags), .addressed_o(addressed));

   bus_master_model m (.scl_low_o(m_scl_low), .sda_low_o(m_sda_low),
      .scl_i(scl_w), .sda_i(sda_w));

   task automatic check(string name, logic [7:0] seen, logic [7:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("BAD %s expected %h seen %h", name, exp, seen);
      end
   endtask

   // read data lands the cycle after the strobe
   always @(posedge clk_i) begin
      logic [15:0] n;
      if (rd_q) begin
         n = note_q.pop_front();
         check("rdata", rdata & n[15:8], n[7:0]);
      end
      rd_q <= sfr.rd;
   end

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk_i);
      sfr <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
      @(posedge clk_i);
      sfr <= '{default: '0};
   endtask

   task automatic rd(input logic [7:0] a, input logic [7:0] m,
                     input logic [7:0] e);
      note_q.push_back({m, e & m});
      @(posedge clk_i);
      sfr <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
      @(posedge clk_i);
      sfr <= '{default: '0};
      @(posedge clk_i);
   endtask

   task automatic pulse(input engine_evt_t e);
      @(posedge clk_i);
      evt <= e;
      @(posedge clk_i);
      evt <= '0;
   endtask

   task automatic addr_case(input logic [6:0] own, input logic [6:0] msk,
                            input logic gc, input logic [6:0] a,
                            input logic exp);
      logic ackl;
      wr(8'hf4, {own, gc});
      wr(8'hf5, {msk, 1'b1});
      m.xfer({a, 1'b0}, ackl);
      check("ack slot", {7'h00, ackl}, {7'h00, exp});
      check("addressed", {7'h00, addressed}, {7'h00, exp});
      check("scl hold", {7'h00, scl_oe}, {7'h00, exp});
      rd(8'hc0, 8'hff, exp ? 8'h21 : 8'h20);
      wr(8'hc0, 8'h00);
      m.stop();
      rd(8'hc0, 8'hff, exp ? 8'h11 : 8'h00);
      wr(8'hc0, 8'h00);
   endtask

   task automatic test_done();
      $display("mismatches %0d comparisons %0d", n_mismatch, cmp_count);
      if (n_mismatch == 0 && cmp_count > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask

   initial begin
      #3000000;
      n_mismatch++;
      test_done();
   end

   initial begin
      logic [6:0] o, k, a;
      logic       g, ackl;
      int         n;
      sfr = '{default: '0};
      evt = '0;
      tb_scl_low = 1'b0;
      tb_sda_low = 1'b0;
      tab = '{32'h347f0341, 32'h347f0000, 32'h347f1001, 32'h347e0351,
              32'h347e0360, 32'h70730741, 32'h70730781, 32'h707307c1,
              32'h70730710, 32'h70730701};
      void'($urandom(38));
      repeat (8) @(posedge clk_i);
      rstn_i <= 1'b1;
      rd(8'hc0, 8'hff, 8'h00);
      rd(8'hc2, 8'hff, 8'h00);
      rd(8'hf4, 8'hff, 8'h00);
      rd(8'hf5, 8'hff, 8'hfe);
      wr(8'hc7, 8'h5a);
      rd(8'hc7, 8'hff, 8'h00);
      wr(8'hf4, 8'ha5);
      rd(8'hf4, 8'hff, 8'ha5);
      wr(8'hf5, 8'h3c);
      rd(8'hf5, 8'hff, 8'h3c);
      // engine events
      pulse('{start_gen: 1'b1, default: 1'b0});
      rd(8'hc0, 8'hc1, 8'hc1);
      pulse('{scl_low_cond: 1'b1, default: 1'b0});
      rd(8'hc0, 8'he5, 8'h05);
      wr(8'hc0, 8'h00);
      rd(8'hc0, 8'h05, 8'h00);
      pulse('{start_gen: 1'b1, default: 1'b0});
      wr(8'hc2, 8'h3b);
      wr(8'hc0, 8'h00);
      rd(8'hc0, 8'h40, 8'h40);
      wr(8'hc0, 8'h01);
      wr(8'hc0, 8'h00);
      rd(8'hc0, 8'h40, 8'h00);
      pulse('{stop_gen: 1'b1, default: 1'b0});
      rd(8'hc0, 8'h80, 8'h00);
      // sda low while driving a one, scl held low to avoid bus events
      tb_scl_low <= 1'b1;
      repeat (4) @(posedge clk_i);
      tb_sda_low <= 1'b1;
      pulse('{start_gen: 1'b1, default: 1'b0});
      wr(8'hc0, 8'h00);
      evt <= '{tx_one: 1'b1, default: 1'b0};
      tb_scl_low <= 1'b0;
      repeat (6) @(posedge clk_i);
      evt <= '0;
      rd(8'hc0, 8'h84, 8'h04);
      tb_sda_low <= 1'b0;
      repeat (4) @(posedge clk_i);
      tb_scl_low <= 1'b0;
      // second reset in mid-run
      rstn_i <= 1'b0;
      repeat (3) @(posedge clk_i);
      rstn_i <= 1'b1;
      rd(8'hc0, 8'hff, 8'h00);
      foreach (tab[i]) begin
         addr_case(tab[i][30:24], tab[i][22:16], tab[i][12], tab[i][10:4],
                   tab[i][0]);
      end
      repeat (6) begin
         o = 7'($urandom());
         k = 7'($urandom());
         g = 1'($urandom());
         a = ($urandom() % 2) ? (o ^ (7'($urandom()) & ~k)) : 7'($urandom());
         addr_case(o, k, g, a, (((a ^ o) & k) == 7'h00) ||
                   (g && a == 7'h00));
      end
      // software acknowledge mode
      wr(8'hf5, 8'hfe);
      fork
         m.xfer(8'h42, ackl);
         begin
            n = 0;
            while (flags.si !== 1'b1 && n < 2000) begin
               @(posedge clk_i);
               n++;
            end
            rd(8'hc0, 8'hff, 8'h29);
            check("scl hold", {7'h00, scl_w}, 8'h00);
            wr(8'hc0, 8'h22);
         end
      join
      check("ack slot", {7'h00, ackl}, 8'h01);
      rd(8'hc0, 8'hff, 8'h22);
      wr(8'hc0, 8'h00);
      m.stop();
      repeat (4) @(posedge clk_i);
      test_done();
   end
endmodule // smbus_flag_and_address_match_bench
